//--- pkg/bec_map.vh
// Behaviour
// RL1: Code 60H adds pending full-line reads each cycle
// RL2: 60H counts only cacheable data/L2-prefetch reads
// RL3: Code 61H counts own bus-not-ready assertions
// RL4: One not-ready count equals two bus cycles
// RL5: Assert not-ready as outstanding nears maximum
// RL6: No new issue while not-ready asserted
// RL7: Code 62H counts data-valid strobe cycles
// RL8: Own qualifier counts only own data drive
// RL9: All-agents qualifier counts any agent's data
// RL10: Code 63H counts cycles with bus lock
// RL11: Lock for uncacheable, split, uncacheable walk
// RL12: Software should avoid bus-locking accesses
// RL13: Code 64H counts receive-busy cycles
// RL14: Code 65H counts each burst read once
// RL15: Burst read count excludes ownership reads
// RL16: Unit mask restricts core and agent; core bits act only on 64H and 65H, and 61H ignores the mask
// RL17: Unknown code leaves counter unchanged
`ifndef BEC_MAP_VH
`define BEC_MAP_VH

// ***********************************
// Register byte offsets
// ***********************************
`define BEC_OFS_CTRL    4'h0
`define BEC_OFS_COUNT   4'h4
`define BEC_OFS_STATUS  4'h8

// ***********************************
// Control field positions
// ***********************************
`define BEC_SEL_LSB     0
`define BEC_SEL_MSB     7
`define BEC_UM_LSB      8
`define BEC_UM_MSB      15
`define BEC_EN_BIT      16
`define BEC_UM_CORE0    8
`define BEC_UM_CORE1    9
`define BEC_UM_ALLAG    13
`define BEC_CTRL_RST    32'h00000000
`define BEC_COUNT_RST   32'h00000000

// ***********************************
// Selection codes
// ***********************************
`define BEC_EV_PEND     8'h60
`define BEC_EV_NRDY     8'h61
`define BEC_EV_DVAL     8'h62
`define BEC_EV_LOCK     8'h63
`define BEC_EV_RCV      8'h64
`define BEC_EV_BRD      8'h65

// ***********************************
// Transaction type codes
// ***********************************
`define BEC_TT_L1D_RD   3'h0
`define BEC_TT_L2PF_RD  3'h1
`define BEC_TT_OWN_RD   3'h2
`define BEC_TT_IFETCH   3'h3
`define BEC_TT_WB       3'h4
`define BEC_TT_PWR      3'h5

// ***********************************
// Timing
// ***********************************
`define BEC_NRDY_CYCLES 2

// ***********************************
// Bus answers
// ***********************************
`define BEC_RESP_OKAY   2'h0
`define BEC_RESP_SLVERR 2'h2

`endif

//--- rtl/bec_sync.v
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// Two-flop synchroniser, one per bit
// ***********************************
module bec_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Pins in, clean levels out
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;  // First stage, read only by second
      reg sync_reg;  // Second stage, safe to use
      // Plain two-stage chain
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/bec_pend.v
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// Outstanding read tracker
// ***********************************
module bec_pend #(
  parameter CW = 6
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // Issue and completion pulses
  input  wire          issue,
  input  wire          done,
  // Reads now pending
  output wire [CW-1:0] pend
);
  reg [CW-1:0] pend_reg;   // Pending count
  reg [CW-1:0] pend_next;  // Next count

  // Issue counts from the cycle after, done retires it the cycle after
  always @* begin
    pend_next = pend_reg;
    if (issue && !done)
      pend_next = pend_reg + {{(CW-1){1'b0}}, 1'b1};
    else if (done && !issue && pend_reg != {CW{1'b0}})
      pend_next = pend_reg - {{(CW-1){1'b0}}, 1'b1};
  end

  // Count register
  always @(posedge aclk) begin
    if (!aresetn)
      pend_reg <= {CW{1'b0}};
    else
      pend_reg <= pend_next;
  end

  assign pend = pend_reg;
endmodule
`default_nettype wire

//--- rtl/bec_top.v
`timescale 1ns/1ps
`default_nettype none
`include "bec_map.vh"
// ***********************************
// Bus event selector and counter
// ***********************************
module bec_top #(
  parameter CW       = 6,  // Pending counter width
  parameter NRDY_MAX = 6   // Own outstanding that raises not-ready
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Shared bus pins, sampled
  input  wire        bus_not_ready_in,
  input  wire        data_valid_strobe,
  input  wire        data_own_drive,
  input  wire        lock_in,
  input  wire        txn_issue,
  input  wire [2:0]  txn_type,
  input  wire        txn_cacheable,
  input  wire        txn_own,
  input  wire        txn_core,
  input  wire        rd_done,
  input  wire        rd_done_own,
  // Shared bus pins, driven
  output reg         bus_not_ready_out,
  output reg         bus_not_ready_oe,
  output reg         lock_out,
  output reg         lock_oe,
  // Core side
  input  wire [1:0]  rcv_busy,
  input  wire        lock_req_uc,
  input  wire        lock_req_split,
  input  wire        lock_req_walk_uc,
  output wire        issue_hold
);

  // ***********************************
  // Pin synchronisers
  // ***********************************
  localparam SW = 16;
  wire [SW-1:0] pin_raw;   // Raw pins
  wire [SW-1:0] pin_s;     // Synchronised pins

  assign pin_raw = {bus_not_ready_in, data_valid_strobe, data_own_drive,
                    lock_in, txn_issue, txn_type, txn_cacheable, txn_own,
                    txn_core, rd_done, rd_done_own, rcv_busy,
                    1'b0};

  bec_sync #(
    .W (SW)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (pin_raw),
    .sync_out (pin_s)
  );

  wire       nrdy_s  = pin_s[15];  // Not-ready seen on bus
  wire       dvs_s   = pin_s[14];  // Data valid strobe
  wire       down_s  = pin_s[13];  // We drive the data
  wire       lock_s  = pin_s[12];  // Lock on the bus
  wire       iss_s   = pin_s[11];  // Transaction issued
  wire [2:0] ttyp_s  = pin_s[10:8];
  wire       tcach_s = pin_s[7];
  wire       town_s  = pin_s[6];
  wire       tcore_s = pin_s[5];
  wire       done_s  = pin_s[4];
  wire       downr_s = pin_s[3];
  wire [1:0] rcv_s   = pin_s[2:1];

  // ***********************************
  // Registers
  // ***********************************
  reg  [31:0] ctrl_reg;    // Select, unit mask, enable
  reg  [31:0] count_reg;   // Event counter
  reg  [31:0] count_next;  // Counter next value
  reg  [31:0] count_inc;   // This cycle's increment

  wire [7:0] ev_sel  = ctrl_reg[`BEC_SEL_MSB:`BEC_SEL_LSB];
  wire       ev_en   = ctrl_reg[`BEC_EN_BIT];
  wire       um_c0   = ctrl_reg[`BEC_UM_CORE0];
  wire       um_c1   = ctrl_reg[`BEC_UM_CORE1];
  wire       um_all  = ctrl_reg[`BEC_UM_ALLAG];

  // ***********************************
  // Transaction classification
  // ***********************************
  // Only cacheable data-cache or L2 prefetch line reads
  wire rd_line = (ttyp_s == `BEC_TT_L1D_RD ||
                  ttyp_s == `BEC_TT_L2PF_RD) && tcach_s;  // RL2
  // Burst reads add cacheable fetch misses, never ownership reads
  wire rd_burst = rd_line ||
                  (ttyp_s == `BEC_TT_IFETCH && tcach_s);  // RL14 RL15
  // Core qualifier from the unit mask
  wire core_hit = tcore_s ? um_c1 : um_c0;  // RL16

  // ***********************************
  // Pending read trackers
  // ***********************************
  wire [CW-1:0] pend_all;  // All agents
  wire [CW-1:0] pend_own;  // This agent only

  bec_pend #(
    .CW (CW)
  ) u_pend_all (
    .aclk    (aclk),
    .aresetn (aresetn),
    .issue   (iss_s && rd_line),
    .done    (done_s),
    .pend    (pend_all)
  );

  bec_pend #(
    .CW (CW)
  ) u_pend_own (
    .aclk    (aclk),
    .aresetn (aresetn),
    .issue   (iss_s && rd_line && town_s),
    .done    (done_s && downr_s),
    .pend    (pend_own)
  );

  // ***********************************
  // Not-ready and lock drive
  // ***********************************
  // Raise not-ready near the outstanding limit
  wire nrdy_want = (pend_own >= NRDY_MAX[CW-1:0]);  // RL5
  wire lock_want = lock_req_uc || lock_req_split ||
                   lock_req_walk_uc;             // RL11
  reg  nrdy_phase_reg;  // Half of a two-cycle assertion

  // Not-ready held in whole two-cycle units
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_not_ready_out <= 1'b0;
      bus_not_ready_oe  <= 1'b0;
      nrdy_phase_reg    <= 1'b0;
    end else if (bus_not_ready_oe && !nrdy_phase_reg) begin
      nrdy_phase_reg <= 1'b1;  // RL4
    end else begin
      bus_not_ready_out <= nrdy_want;
      bus_not_ready_oe  <= nrdy_want;
      nrdy_phase_reg    <= 1'b0;
    end
  end

  // Lock pin follows the core's locked requests
  always @(posedge aclk) begin
    if (!aresetn) begin
      lock_out <= 1'b0;
      lock_oe  <= 1'b0;
    end else begin
      lock_out <= lock_want;  // RL11
      lock_oe  <= lock_want;
    end
  end

  // Core stops issuing while anyone holds not-ready
  assign issue_hold = nrdy_s || bus_not_ready_oe;  // RL6

  // ***********************************
  // Event selection
  // ***********************************
  // Increment per cycle for the chosen code
  always @* begin
    count_inc = 32'h00000000;
    case (ev_sel)
      `BEC_EV_PEND: begin
        // Add the reads pending this cycle, all agents' or own only
        if (um_all)
          count_inc = {{(32-CW){1'b0}}, pend_all};  // RL1
        else
          count_inc = {{(32-CW){1'b0}}, pend_own};
      end
      `BEC_EV_NRDY: begin
        // One count per own two-cycle assertion
        if (bus_not_ready_oe && !nrdy_phase_reg)
          count_inc = 32'h00000001;  // RL3 RL4
      end
      `BEC_EV_DVAL: begin
        if (um_all && dvs_s)
          count_inc = 32'h00000001;  // RL7 RL9
        else if (!um_all && dvs_s && down_s)
          count_inc = 32'h00000001;  // RL8
      end
      `BEC_EV_LOCK: begin
        // Own lock uses our own drive
        if (um_all ? lock_s : lock_oe)
          count_inc = 32'h00000001;  // RL10
      end
      `BEC_EV_RCV: begin
        if ((rcv_s[0] && um_c0) || (rcv_s[1] && um_c1))
          count_inc = 32'h00000001;  // RL13 RL16
      end
      `BEC_EV_BRD: begin
        // Counted once, on the issue cycle
        if (iss_s && rd_burst && core_hit && (um_all || town_s))
          count_inc = 32'h00000001;  // RL14
      end
      default: begin
        count_inc = 32'h00000000;  // RL17
      end
    endcase
  end

  // ***********************************
  // AXI4-Lite write channel
  // ***********************************
  reg        aw_full_reg;  // Address held
  reg [3:0]  aw_addr_reg;  // Held address
  reg        w_full_reg;   // Data held
  reg [31:0] w_data_reg;   // Held data
  reg [3:0]  w_strb_reg;   // Held strobes

  // One write at a time; take address and data in any order
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;

  wire wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire wr_ctrl  = wr_go && aw_addr_reg[3:2] == `BEC_OFS_CTRL >> 2;
  wire wr_count = wr_go && aw_addr_reg[3:2] == `BEC_OFS_COUNT >> 2;
  wire wr_stat  = wr_go && aw_addr_reg[3:2] == `BEC_OFS_STATUS >> 2;

  // Byte-lane merge of held data into a register
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  // Capture, commit and respond
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BEC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        // Status is read only, so writing it is an error
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ctrl || wr_count) ? `BEC_RESP_OKAY
                                              : `BEC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***********************************
  // Control and counter
  // ***********************************
  // Software load beats counting in the same cycle
  always @* begin
    count_next = count_reg;
    if (wr_count)
      count_next = lane_merge(count_reg, w_data_reg, w_strb_reg);
    else if (ev_en)
      count_next = count_reg + count_inc;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= `BEC_CTRL_RST;
      count_reg <= `BEC_COUNT_RST;
    end else begin
      count_reg <= count_next;
      if (wr_ctrl)
        ctrl_reg <= lane_merge(ctrl_reg, w_data_reg, w_strb_reg) &
                    32'h0001FFFF;
    end
  end

  // ***********************************
  // AXI4-Lite read channel
  // ***********************************
  // One read at a time; answer the cycle after
  assign s_axi_arready = !s_axi_rvalid;

  reg [31:0] rd_mux;   // Selected read data
  reg        rd_ok;    // Address mapped

  // Read decode
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr[3:2])
      `BEC_OFS_CTRL >> 2:   rd_mux = ctrl_reg;
      `BEC_OFS_COUNT >> 2:  rd_mux = count_reg;
      `BEC_OFS_STATUS >> 2: begin
        // Own pending, not-ready and lock drive
        rd_mux = {22'h000000, lock_oe, bus_not_ready_oe,
                  {(8-CW){1'b0}}, pend_own};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read answer register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? `BEC_RESP_OKAY : `BEC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- tb/bec_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the event counter
// ****************************************
module bec_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Shared bus drive and core side
  input wire logic        bus_not_ready_out,
  input wire logic        bus_not_ready_oe,
  input wire logic        issue_hold,
  input wire logic        lock_req_uc,
  input wire logic        lock_req_split,
  input wire logic        lock_req_walk_uc,
  input wire logic        lock_out,
  input wire logic        lock_oe
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire lreq = lock_req_uc || lock_req_split || lock_req_walk_uc;

  property p_rd_turn;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_turn: assert property (p_rd_turn) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  // A drive never lasts a single cycle
  property p_nrdy_pair;
    $rose(bus_not_ready_out) |=> bus_not_ready_out;
  endproperty
  a_nrdy_pair: assert property (p_nrdy_pair) else $error("lone not-ready");
  property p_nrdy_hold;
    bus_not_ready_out |-> bus_not_ready_oe && issue_hold;
  endproperty
  a_nrdy_hold: assert property (p_nrdy_hold) else $error("issue not held");
  property p_lock_on;
    lreq |=> lock_out && lock_oe;
  endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock not driven");
  property p_lock_off;
    !lreq |=> !lock_oe;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("stray lock");
  c_nrdy: cover property (bus_not_ready_out);
  c_lock: cover property (lock_oe);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind bec_top bec_sva u_sva (.*);
`default_nettype wire

//--- tb/bec_agent.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Other agents on the shared bus
// ****************************************
module bec_agent (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Commands from the bench
  input  wire logic       go,
  input  wire logic [3:0] len,
  input  wire logic       full,
  // Our device's not-ready drive
  input  wire logic       hold,
  // Bus levels from the other agents
  output logic            dvs,
  output logic            lock,
  output logic            nrdy
);
  logic [3:0] left_reg; // Data cycles still to send
  logic       want_reg; // Transfer waiting for the bus
  // Burst engine, waits out a not-ready before it starts
  always @(posedge aclk) begin
    if (!aresetn) begin
      left_reg <= 4'h0;
      want_reg <= 1'b0;
      nrdy <= 1'b0;
    end else begin
      if ((want_reg || go) && !hold && left_reg == 4'h0) begin
        left_reg <= len;
        want_reg <= 1'b0;
      end else begin
        if (go) want_reg <= 1'b1;
        if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
      end
      nrdy <= full;
    end
  end
  // A locked burst: data and lock stand together
  assign dvs = left_reg != 4'h0;
  assign lock = dvs;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Bench signals
  // ****************************************
  logic        aclk, aresetn, awv, wv, br, arv, rr, txi, tc, rdd, odd;
  logic [3:0]  awa, ara, blen;
  logic [31:0] wd;
  logic [2:0]  tt;
  logic [4:0]  sel;   // One-hot stimulus pick
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awr, wrd, bv, arr, rv, nrdy_o, dvs, lk, nrdy_i;
  integer      fails, cmp_count, cyc, nrdy_cyc, i;

  bec_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .bus_not_ready_in(nrdy_i), .data_valid_strobe(dvs),
    .data_own_drive(odd), .lock_in(lk), .txn_issue(txi), .txn_type(tt),
    .txn_cacheable(tc), .txn_own(1'b1), .txn_core(1'b0), .rd_done(rdd),
    .rd_done_own(1'b1), .bus_not_ready_out(nrdy_o), .bus_not_ready_oe(),
    .lock_out(), .lock_oe(), .rcv_busy({1'b0, sel[1]}),
    .lock_req_uc(sel[2]), .lock_req_split(sel[3]),
    .lock_req_walk_uc(sel[4]), .issue_hold());
  bec_agent u_agent (.aclk(aclk), .aresetn(aresetn), .go(sel[0]),
    .len(blen), .full(1'b0), .hold(nrdy_o), .dvs(dvs), .lock(lk),
    .nrdy(nrdy_i));

  // Clock, hang guard and not-ready cycle tally
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (nrdy_o === 1'b1) nrdy_cyc <= nrdy_cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end

  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic chk(input string nm, input [31:0] e, input [31:0] s);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Ready is sampled mid-cycle, where it is settled until the edge
  task automatic axw(input [3:0] a, input [31:0] d, input [1:0] er);
    logic ah, wh, bh;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = awv && awr;
      wh = wv && wrd;
      bh = bv;
      if (bh) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    br <= 1'b0;
    // Let an edge pass so a next call never re-raises it in this step
    @(posedge aclk);
  endtask
  task automatic axr(input [3:0] a, input [31:0] e, input [1:0] er,
                     input string nm);
    logic ah, rh;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = arv && arr;
      rh = rv;
      if (rh) chk(nm, e, rdata);
      if (rh) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge aclk);
      if (ah) arv <= 1'b0;
    end
    rr <= 1'b0;
    // Same spacing as writes between back-to-back reads
    @(posedge aclk);
  endtask
  // Program, clear, stimulate n cycles, then read back the count
  task automatic run(input string nm, input [31:0] ctl, input [2:0] k,
                     input [3:0] n, input [31:0] e);
    axw(4'h0, ctl, 2'h0);
    axw(4'h4, 32'h0, 2'h0);
    blen <= n;
    sel <= 5'h1 << k;
    repeat (k == 3'h0 ? 4'h1 : n) @(posedge aclk);
    sel <= 5'h0;
    repeat (12) @(posedge aclk);
    axr(4'h4, e, 2'h0, nm);
    $display("test %s done", nm);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awv, wv, br, arv, rr, txi, tc, rdd, odd} = 9'h0;
    {awa, ara, blen, tt, sel, wd} = 52'h0;
    {fails, cmp_count, cyc, nrdy_cyc} = 128'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(4'h0, 32'h0, 2'h0, "ctrl reset");
    axr(4'hC, 32'h0, 2'h2, "unmapped");
    axw(4'h8, 32'hFFFFFFFF, 2'h2);
    axr(4'h8, 32'h0, 2'h0, "status");
    axw(4'h0, 32'hFFFFFFFF, 2'h0);
    axr(4'h0, 32'h0001FFFF, 2'h0, "ctrl bits");
    $display("test registers done");
    run("dvalid all", 32'h00012062, 3'h0, 4'h5, 32'h5);
    run("dvalid own idle", 32'h00010062, 3'h0, 4'h5, 32'h0);
    odd <= 1'b1;
    run("dvalid own", 32'h00010062, 3'h0, 4'h5, 32'h5);
    odd <= 1'b0;
    // Locks kept short and few, as software is asked to do
    run("lock all", 32'h00012063, 3'h0, 4'h4, 32'h4);
    for (i = 2; i < 5; i++) run("lock own", 32'h00010063, i[2:0], 4'h3, 32'h3);
    run("rcv core0", 32'h00010164, 3'h1, 4'h4, 32'h4);
    run("rcv core1", 32'h00010264, 3'h1, 4'h4, 32'h0);
    run("unknown", 32'h00012066, 3'h0, 4'h5, 32'h0);
    run("disabled", 32'h00002062, 3'h0, 4'h5, 32'h0);
    // Every type, then one uncacheable read; two reads go pending, then both retire
    axw(4'h0, 32'h00010165, 2'h0);
    axw(4'h4, 32'h0, 2'h0);
    txi <= 1'b1;
    tc <= 1'b1;
    for (i = 0; i < 6; i++) begin
      tt <= i[2:0];
      @(posedge aclk);
    end
    tc <= 1'b0;
    tt <= 3'h0;
    @(posedge aclk);
    txi <= 1'b0;
    rdd <= 1'b1;
    repeat (2) @(posedge aclk);
    rdd <= 1'b0;
    repeat (8) @(posedge aclk);
    axr(4'h4, 32'h3, 2'h0, "burst reads");
    $display("test burst done");
    // One line read pending ten cycles, an ownership read beside it
    axw(4'h0, 32'h00010060, 2'h0);
    axw(4'h4, 32'h0, 2'h0);
    txi <= 1'b1;
    tc <= 1'b1;
    @(posedge aclk);
    tt <= 3'h2;
    @(posedge aclk);
    txi <= 1'b0;
    repeat (8) @(posedge aclk);
    rdd <= 1'b1;
    @(posedge aclk);
    rdd <= 1'b0;
    repeat (8) @(posedge aclk);
    axr(4'h4, 32'hA, 2'h0, "pending");
    $display("test pending done");
    // Fill to the limit so the device drives not-ready
    axw(4'h0, 32'h00010061, 2'h0);
    axw(4'h4, 32'h0, 2'h0);
    txi <= 1'b1;
    tt <= 3'h0;
    repeat (6) @(posedge aclk);
    txi <= 1'b0;
    repeat (10) @(posedge aclk);
    axr(4'h8, 32'h106, 2'h0, "status busy");
    rdd <= 1'b1;
    repeat (6) @(posedge aclk);
    rdd <= 1'b0;
    repeat (12) @(posedge aclk);
    // Drive lasts from six pending to the first retire: seven pairs
    axr(4'h4, 32'h7, 2'h0, "not ready");
    chk("not ready cycles", 32'hE, nrdy_cyc);
    $display("test not ready done");
    report_and_stop;
  end
endmodule
`default_nettype wire
